/* File: rtl/sram_ctl_params.svh */
`ifndef SRAM_CTL_PARAMS_SVH
`define SRAM_CTL_PARAMS_SVH

// ==========================================================
// register block placement (word index, top bit of high nibble from module map)
`define REG_BLOCK_LOW 20'hFFB40
`define REG_BLOCK_NIBBLE_LOW 3'b111
`define IDX_CONFIG 20'h00000
`define IDX_TEST 20'h00002
`define IDX_BASE_HIGH 20'h00004
`define IDX_BASE_LOW 20'h00006

// ==========================================================
// field positions and reset values
`define CONFIG_RESET 16'h8300
`define STOP_BIT 15
`define LOCK_BIT 11
`define SPACE_HI 9
`define SPACE_LO 8
`define BASE_HIGH_MASK 16'h00FF
`define BASE_HIGH_RESET 16'h0000
`define BASE_LOW_MASK 16'hF800
`define BASE_LOW_RESET 16'h0000

// ==========================================================
// array geometry: 1K words of 16 bits, base compared on ADDR[23:11]
`define ARRAY_AW 10
`define ARRAY_WORDS 1024

`endif

/* File: rtl/sram_ctl_pkg.sv */
package sram_ctl_pkg;

  // ==========================================================
  // array space encodings
  typedef enum logic [1:0] {
    SPACE_ANY_PD = 2'b00,
    SPACE_ANY_P = 2'b01,
    SPACE_SUP_PD = 2'b10,
    SPACE_SUP_P = 2'b11
  } space_type;

  // ==========================================================
  // register bus handshake state
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_type;

  // ==========================================================
  // array access request and answer
  typedef struct packed {
    logic valid;
    logic we;
    logic supv;
    logic prog;
    logic [23:1] addr;
    logic [15:0] wdata;
  } array_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } array_rsp_type;

  // ==========================================================
  // configuration register contents
  typedef struct packed {
    logic stop;
    logic lock;
    space_type space;
  } config_type;

endpackage

/* File: rtl/space_check.sv */
module space_check
  import sram_ctl_pkg::*;
(
  input wire sram_ctl_pkg::space_type space,
  input wire logic supv,
  input wire logic prog,
  output logic allow
);

  // ==========================================================
  // space field permission
  always_comb
  begin
    unique case (space)
      SPACE_ANY_PD: allow = 1'b1;
      SPACE_ANY_P: allow = prog;
      SPACE_SUP_PD: allow = supv;
      SPACE_SUP_P: allow = supv & prog;
    endcase
  end

endmodule // space_check

/* File: rtl/sram_store.sv */
`include "sram_ctl_params.svh"

module sram_store
(
  input wire logic clk,
  input wire logic en,
  input wire logic we,
  input wire logic [`ARRAY_AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  logic [15:0] mem [0:`ARRAY_WORDS-1];

  // ==========================================================
  // storage; contents hold whenever en is low
  always_ff @(posedge clk)
  begin
    if (en)
    begin
      if (we)
      begin
        mem[addr] <= wdata;
      end
    end
  end

  // read is asynchronous; the caller registers the old word with its answer
  assign rdata = mem[addr];

endmodule // sram_store

/* File: rtl/sram_ctl.sv */
// How it works
// - register reads and writes are taken only from supervisor-level bus accesses
// - four 16-bit registers: config, test, base high, base low, two apart
// - register block top nibble is the module-mapping bit followed by 111
// - stop bit set keeps array contents but refuses every array access
// - base-lock bit set blocks writes to both base registers
// - base-lock clears on reset, software may set it once, stays set
// - space field limits array accesses by privilege and program/data kind
// - base-high low byte holds address bits 23:16, upper byte unused, resets zero
// - base registers written only while stopped and unlocked
//
// Chosen here: the placing of the registers and register access over Wishbone.
`include "sram_ctl_params.svh"

module sram_ctl
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic MODULE_MAP,
  input wire logic [25:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic SUPV_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  input wire sram_ctl_pkg::array_req_type ARR_REQ,
  output sram_ctl_pkg::array_rsp_type ARR_RSP,
  output logic STOP_MODE
);

  import sram_ctl_pkg::*;

  // ==========================================================
  // declarations
  bus_state_type bus_state;
  bus_state_type next_bus_state;
  logic ack;
  logic next_ack;
  logic err;
  logic next_err;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  config_type cfg;
  config_type next_cfg;
  logic [15:0] base_high;
  logic [15:0] next_base_high;
  logic [15:0] base_low;
  logic [15:0] next_base_low;
  logic arr_ack;
  logic next_arr_ack;
  logic arr_err;
  logic next_arr_err;
  logic [23:0] idx;
  logic hit_config;
  logic hit_test;
  logic hit_base_high;
  logic hit_base_low;
  logic mapped;
  logic request;
  logic take_write;
  logic base_writable;
  logic [15:0] wr_word;
  logic [15:0] wr_mask;
  logic base_match;
  logic space_allow;
  logic array_go;
  logic [15:0] store_rdata;
  logic [15:0] arr_rdata;
  logic [15:0] next_arr_rdata;
  logic [3:0] hit;
  logic refuse;
  logic wr_config;
  logic wr_base_high;
  logic wr_base_low;
  localparam logic [15:0] config_reset = `CONFIG_RESET;
  localparam logic [19:0] reg_offset [0:3] = '{`IDX_CONFIG, `IDX_TEST, `IDX_BASE_HIGH, `IDX_BASE_LOW};

  // ==========================================================
  // register index decode
  function automatic logic reg_hit(input logic [23:0] index, input logic mm, input logic [19:0] off);
    reg_hit = (index == {mm, `REG_BLOCK_NIBBLE_LOW, 20'(`REG_BLOCK_LOW + off)});
  endfunction

  function automatic logic [15:0] config_word(input config_type c);
    config_word = 16'h0000;
    config_word[`STOP_BIT] = c.stop;
    config_word[`LOCK_BIT] = c.lock;
    config_word[`SPACE_HI:`SPACE_LO] = c.space;
  endfunction

  // byte-lane merge of a register write
  function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [15:0] word,
    input logic [15:0] mask);
    merge_bytes = (word & mask) | (old & ~mask);
  endfunction

  assign idx = ADR_I[25:2];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_hit
      assign hit[g] = reg_hit(idx, MODULE_MAP, reg_offset[g]);
    end
  endgenerate

  assign hit_config = hit[0];
  assign hit_test = hit[1];
  assign hit_base_high = hit[2];
  assign hit_base_low = hit[3];
  assign mapped = |hit;

  // ==========================================================
  // bus handshake
  assign request = CYC_I & STB_I & (bus_state == BUS_IDLE);
  assign refuse = ~(mapped & SUPV_I);
  // writes land at the edge where the master samples ack high
  assign take_write = CYC_I & STB_I & WE_I & ack & ~refuse;
  assign wr_config = take_write & hit_config & SEL_I[1];
  assign wr_base_high = take_write & hit_base_high & base_writable;
  assign wr_base_low = take_write & hit_base_low & base_writable;
  assign wr_word = DAT_I[15:0];
  assign wr_mask = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};

  always_comb
  begin
    next_bus_state = BUS_IDLE;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdata = rdata;
    unique case (bus_state)
      BUS_IDLE:
      begin
        if (request)
        begin
          next_bus_state = BUS_ANSWER;
          next_ack = ~refuse;
          next_err = refuse;
          next_rdata = 32'h00000000;
          if (~refuse & ~WE_I)
          begin
            if (hit_config)
            begin
              next_rdata[15:0] = config_word(cfg);
            end
            else if (hit_base_high)
            begin
              next_rdata[15:0] = base_high & `BASE_HIGH_MASK;
            end
            else if (hit_base_low)
            begin
              next_rdata[15:0] = base_low & `BASE_LOW_MASK;
            end
          end
        end
      end
      BUS_ANSWER:
      begin
        next_bus_state = BUS_IDLE;
      end
      default:
      begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bus_state <= BUS_IDLE;
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h00000000;
    end
    else
    begin
      bus_state <= next_bus_state;
      ack <= next_ack;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // control registers: configuration
  assign base_writable = cfg.stop & ~cfg.lock;

  always_comb
  begin
    next_cfg = cfg;
    if (wr_config)
    begin
      next_cfg.stop = wr_word[`STOP_BIT];
      next_cfg.lock = cfg.lock | wr_word[`LOCK_BIT];
      next_cfg.space = space_type'(wr_word[`SPACE_HI:`SPACE_LO]);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cfg.stop <= config_reset[`STOP_BIT];
      cfg.lock <= config_reset[`LOCK_BIT];
      cfg.space <= space_type'(config_reset[`SPACE_HI:`SPACE_LO]);
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // control registers: array base
  always_comb
  begin
    next_base_high = base_high;
    next_base_low = base_low;
    if (wr_base_high)
    begin
      next_base_high = merge_bytes(base_high, wr_word, wr_mask) & `BASE_HIGH_MASK;
    end
    if (wr_base_low)
    begin
      next_base_low = merge_bytes(base_low, wr_word, wr_mask) & `BASE_LOW_MASK;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      base_high <= `BASE_HIGH_RESET;
      base_low <= `BASE_LOW_RESET;
    end
    else
    begin
      base_high <= next_base_high;
      base_low <= next_base_low;
    end
  end

  // ==========================================================
  // array access
  assign base_match = (ARR_REQ.addr[23:11] == {base_high[7:0], base_low[15:11]});

  space_check u_space_check (
    .space(cfg.space),
    .supv(ARR_REQ.supv),
    .prog(ARR_REQ.prog),
    .allow(space_allow)
  );

  assign array_go = ARR_REQ.valid & base_match & space_allow & ~cfg.stop;

  sram_store u_store (
    .clk(SYS_CLK),
    .en(array_go),
    .we(ARR_REQ.we),
    .addr(ARR_REQ.addr[`ARRAY_AW:1]),
    .wdata(ARR_REQ.wdata),
    .rdata(store_rdata)
  );

  always_comb
  begin
    next_arr_ack = array_go;
    next_arr_err = ARR_REQ.valid & base_match & ~array_go;
    next_arr_rdata = array_go ? store_rdata : 16'h0000;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      arr_ack <= 1'b0;
      arr_err <= 1'b0;
      arr_rdata <= 16'h0000;
    end
    else
    begin
      arr_ack <= next_arr_ack;
      arr_err <= next_arr_err;
      arr_rdata <= next_arr_rdata;
    end
  end

  // ==========================================================
  // outputs
  assign ACK_O = ack;
  assign ERR_O = err;
  assign DAT_O = rdata;
  assign STOP_MODE = cfg.stop;
  assign ARR_RSP.ack = arr_ack;
  assign ARR_RSP.err = arr_err;
  assign ARR_RSP.rdata = arr_rdata;

endmodule // sram_ctl

/* File: dv/sram_ctl_checker.sv */
module sram_ctl_checker
  import sram_ctl_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic MODULE_MAP,
  input wire logic [25:0] ADR_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic SUPV_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire sram_ctl_pkg::array_req_type ARR_REQ,
  input wire sram_ctl_pkg::array_rsp_type ARR_RSP,
  input wire logic STOP_MODE
);
  // ==========================================================
  // bus and array port properties
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic req;
  assign req = CYC_I && STB_I && !ACK_O && !ERR_O;
  user_refused_a: assert property (req && !SUPV_I |=> ERR_O && !ACK_O)
    else $error("user access not refused");
  bus_answer_a: assert property (req |=> ACK_O != ERR_O)
    else $error("no single answer");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O && !ERR_O)
    else $error("ack too long");
  hi_zero_a: assert property (ACK_O |-> DAT_O[31:16] == 16'h0000)
    else $error("upper data set");
  map_bit_a: assert property (req && SUPV_I && ADR_I[25] != MODULE_MAP |=> ERR_O)
    else $error("wrong map bit taken");
  stop_refuse_a: assert property (ARR_REQ.valid && STOP_MODE |=> !ARR_RSP.ack && ARR_RSP.rdata == 16'h0000)
    else $error("stopped array answered");
  stop_change_a: assert property ($changed(STOP_MODE) |-> ACK_O || $past(ACK_O))
    else $error("stop moved alone");
  rsp_cause_a: assert property (ARR_RSP.ack || ARR_RSP.err |-> $past(ARR_REQ.valid))
    else $error("answer without request");
endmodule // sram_ctl_checker

bind sram_ctl sram_ctl_checker sram_ctl_checker_i(.SYS_CLK(SYS_CLK), .RST_N(RST_N), .MODULE_MAP(MODULE_MAP),
  .ADR_I(ADR_I), .CYC_I(CYC_I), .STB_I(STB_I), .SUPV_I(SUPV_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .ERR_O(ERR_O), .ARR_REQ(ARR_REQ), .ARR_RSP(ARR_RSP), .STOP_MODE(STOP_MODE));

/* File: dv/array_host.sv */
module array_host
  import sram_ctl_pkg::*;
(
  input wire logic clk,
  output sram_ctl_pkg::array_req_type req,
  input wire sram_ctl_pkg::array_rsp_type rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // ==========================================================
  // one array access, answer taken one cycle after the request
  task access(input logic w, input logic sv, input logic p, input logic [23:1] a, input logic [15:0] wd,
    output logic [17:0] r);
    @(posedge clk);
    req <= '{1'b1, w, sv, p, a, wd};
    @(posedge clk);
    req.valid <= 1'b0;
    req.wdata <= ~wd;
    @(posedge clk);
    r = {rsp.ack, rsp.err, rsp.rdata};
  endtask
endmodule // array_host

/* File: dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ctl_pkg::*;
  logic clk, rst_n, mm, we, cyc, stb, sv, ack, err, stop;
  logic [25:0] adr;
  logic [31:0] dat, dout;
  logic [3:0] sel;
  array_req_type areq;
  array_rsp_type arsp;
  logic [17:0] r;
  logic [22:0] hit;
  int failures, cmp_count;
  sram_ctl sram_ctl_i(.SYS_CLK(clk), .RST_N(rst_n), .MODULE_MAP(mm), .ADR_I(adr), .DAT_I(dat), .SEL_I(sel),
    .WE_I(we), .CYC_I(cyc), .STB_I(stb), .SUPV_I(sv), .DAT_O(dout), .ACK_O(ack), .ERR_O(err),
    .ARR_REQ(areq), .ARR_RSP(arsp), .STOP_MODE(stop));
  array_host array_host_i(.clk(clk), .req(areq), .rsp(arsp));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task complete_run();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [17:0] g, input logic [17:0] x);
    cmp_count++;
    if (g !== x)
    begin
      $display("[ERR] %0t got %h exp %h", $time, g, x);
      failures++;
    end
  endtask
  task wb(input logic w, input logic m, input logic [3:0] o, input logic [15:0] v, input logic p);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sv <= p;
    sel <= 4'h3;
    adr <= {m, 3'b111, 20'hFFB40 + 20'(o), 2'b00};
    dat <= {16'h0000, v};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (!(ack | err) && n < 20);
    r = {ack, err, dout[15:0]};
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20)
    begin
      failures++;
      complete_run();
    end
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    {rst_n, we, cyc, stb, adr, dat, sel} = '0;
    {mm, sv} = 2'b11;
    failures = 0;
    cmp_count = 0;
    hit = {8'hAB, 5'h01, 10'h005};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int o = 0; o < 8; o += 2)
    begin
      wb(0, 1, 4'(o), 0, 1);
      chk(r, o == 0 ? 18'h28300 : 18'h20000);
    end
    wb(0, 1, 0, 0, 0);
    chk(r, 18'h10000);
    wb(0, 0, 0, 0, 1);
    chk(r, 18'h10000);
    wb(0, 1, 8, 0, 1);
    chk(r, 18'h10000);
    wb(1, 1, 4, 16'h12AB, 1);
    wb(0, 1, 4, 0, 1);
    chk(r, 18'h200AB);
    wb(1, 1, 6, 16'h0FFF, 1);
    wb(0, 1, 6, 0, 1);
    chk(r, 18'h20800);
    array_host_i.access(0, 1, 1, hit, 0, r);
    chk(r, 18'h10000);
    wb(1, 1, 0, 16'h0000, 1);
    wb(1, 1, 4, 16'h0055, 1);
    wb(0, 1, 4, 0, 1);
    chk(r, 18'h200AB);
    array_host_i.access(1, 0, 0, hit, 16'hBEEF, r);
    chk({r[17:16], 16'h0000}, 18'h20000);
    array_host_i.access(0, 0, 0, {8'hAC, 15'h0805}, 0, r);
    chk(r, 18'h00000);
    for (int s = 0; s < 4; s++)
    begin
      wb(1, 1, 0, 16'(s << 8), 1);
      for (logic [2:0] k = 0; k < 4; k++)
      begin
        array_host_i.access(0, k[1], k[0], hit, 0, r);
        chk(r, (s == 0 || (s == 1 && k[0]) || (s == 2 && k[1]) || k == 3) ? 18'h2BEEF : 18'h10000);
      end
    end
    wb(1, 1, 0, 16'h8000, 1);
    array_host_i.access(0, 1, 1, hit, 0, r);
    chk(r, 18'h10000);
    chk({17'h00000, stop}, 18'h00001);
    wb(1, 1, 0, 16'h0000, 1);
    array_host_i.access(0, 1, 1, hit, 0, r);
    chk(r, 18'h2BEEF);
    chk({17'h00000, stop}, 18'h00000);
    wb(1, 1, 0, 16'h0800, 1);
    wb(1, 1, 0, 16'h8000, 1);
    wb(0, 1, 0, 0, 1);
    chk(r, 18'h28800);
    wb(1, 1, 4, 16'h0011, 1);
    wb(0, 1, 4, 0, 1);
    chk(r, 18'h200AB);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, 1, 0, 0, 1);
    chk(r, 18'h28300);
    wb(0, 1, 4, 0, 1);
    chk(r, 18'h20000);
    complete_run();
  end
endmodule // testbench
